// >>> verilog/adcf_map.vh
// register offsets, field positions, reset values and timing constants of the converter control block
`ifndef ADCF_MAP_VH
`define ADCF_MAP_VH
// register offsets (index on the plain register port)
`define ADCF_OFS_CONTROL      3'h0
`define ADCF_OFS_REF_CFG      3'h1
`define ADCF_OFS_TIMING_CFG   3'h2
`define ADCF_OFS_RESULT_HIGH  3'h3
`define ADCF_OFS_RESULT_LOW   3'h4
`define ADCF_OFS_STATUS       3'h5
// control register fields
`define ADCF_CTL_ENABLE       0
`define ADCF_CTL_START        1
`define ADCF_CTL_CHAN_LSB     2
// reference config fields
`define ADCF_REF_NEG_LSB      0
`define ADCF_REF_POS_LSB      2
`define ADCF_REF_MASK         8'h0f
// positive reference codes
`define ADCF_POS_SUPPLY       2'h0
`define ADCF_POS_EXT_PIN      2'h1
`define ADCF_POS_FIXED        2'h2
// negative reference codes
`define ADCF_NEG_GROUND       2'h0
`define ADCF_NEG_EXT_PIN      2'h1
// timing config fields
`define ADCF_TIM_JUSTIFY      7
`define ADCF_TIM_ACQ_LSB      3
`define ADCF_TIM_CLK_LSB      0
`define ADCF_TIM_MASK         8'hbf
// reset values
`define ADCF_RST_REF          8'h00
`define ADCF_RST_TIMING       8'h00
// timing: conversion periods per conversion, gap after conversion
`define ADCF_RESULT_BITS      10
`define ADCF_GAP_PERIODS      2
// internal rc clock: nominal 600 kHz; system clock 25 MHz
`define ADCF_RC_FREQ_KHZ      600
`define ADCF_SYS_FREQ_KHZ     25000
// one instruction cycle is four system clocks
`define ADCF_INSTR_CLOCKS     4
// last counts of the one-instruction hold and of the gap, sized for their 2-bit counters
`define ADCF_HOLD_LAST        2'h3
`define ADCF_GAP_LAST         2'h1
`endif

// >>> verilog/adcf_tick_gen.v
// conversion clock period tick generator: system clock divider or internal rc source
`timescale 1ns/1ps
`default_nettype none
`include "adcf_map.vh"
module adcf_tick_gen
#(
  parameter RC_DIV = (`ADCF_SYS_FREQ_KHZ / `ADCF_RC_FREQ_KHZ)
)
(
  input  wire       clock,
  input  wire       arst_n,
  input  wire       run,
  input  wire [2:0] clk_sel,
  output reg        tick
);
  reg  [6:0] count;
  reg  [6:0] limit;
  // rc ratio minus one, kept 32 bits wide so the cut to 7 bits below is deliberate
  localparam [31:0] RC_LAST = RC_DIV - 1;

  // divide ratio minus one; codes 011 and 111 pick the rc rate, which the
  // model approximates from the system clock since there is no second domain
  always @*
  begin
    case (clk_sel)
      3'h0:    limit = 7'h01;
      3'h1:    limit = 7'h07;
      3'h2:    limit = 7'h1f;
      3'h4:    limit = 7'h03;
      3'h5:    limit = 7'h0f;
      3'h6:    limit = 7'h3f;
      default: limit = RC_LAST[6:0];
    endcase // R7
  end

  // free count while running; restarts so each period is whole
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= 7'h00;
      tick  <= 1'b0;
    end
    else if (!run)
    begin
      count <= 7'h00;
      tick  <= 1'b0;
    end
    else if (count >= limit)
    begin
      count <= 7'h00;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 7'h01;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> verilog/adcf_core.v
// converter control, sequencing and result formatting of the 10-bit approximation converter
//
// Operation
// R1 - positive reference: supply, external pin, fixed
// R2 - negative reference: ground or external pin
// R3 - reference config upper nibble reads zero
// R4 - bit 7 picks justification; bit 6 zero
// R5 - acquisition delay codes 0..20 periods
// R6 - sample channel for delay, then convert
// R7 - clock divider codes 2,8,32,4,16,64
// R8 - codes 011 and 111 pick rc clock
// R9 - rc clock delays start one instruction
// R10 - left: high byte holds bits 9..2
// R11 - left: low byte bits 7,6 hold 1..0
// R12 - right: high byte bits 1,0 hold 9..8
// R13 - right: low byte holds bits 7..0
// R14 - software allows acquisition before starting conversion
// R15 - discharge sampling capacitor after every conversion
// R16 - completion clears start, sets flag, writes result
// R17 - early clear aborts; fill with last bit
// R18 - wait two periods before next acquisition
// R19 - configuration resets to zero
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "adcf_map.vh"
module adcf_core
#(
  parameter RC_DIV = (`ADCF_SYS_FREQ_KHZ / `ADCF_RC_FREQ_KHZ)
)
(
  input  wire       clock,
  input  wire       arst_n,
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  input  wire       comp_in,
  output reg  [1:0] pos_ref_sel,
  output reg  [1:0] neg_ref_sel,
  output reg  [3:0] chan_sel,
  output reg        sample_connect,
  output reg        sample_discharge,
  output reg  [9:0] dac_code,
  output reg        conv_done_flag
);
  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_HOLD  = 6'h02;
  localparam [5:0] ST_ACQ   = 6'h04;
  localparam [5:0] ST_CONV  = 6'h08;
  localparam [5:0] ST_DISCH = 6'h10;
  localparam [5:0] ST_GAP   = 6'h20;
  // ----------------------------------------------------------------------
  // storage and wires
  // ----------------------------------------------------------------------
  reg  [7:0] reference_config;
  reg  [7:0] timing_format_config;
  reg  [7:0] result_high_byte;
  reg  [7:0] result_low_byte;
  reg        conv_enable;
  reg        start_busy;
  reg  [5:0] state;
  reg  [4:0] acq_count;
  reg  [4:0] acq_target;
  reg  [3:0] bit_index;
  reg  [9:0] sar;
  reg  [1:0] gap_count;
  reg  [1:0] hold_count;
  reg        comp_meta;
  reg        comp_sync;
  reg  [9:0] next_result;
  reg  [9:0] filled;
  reg        last_bit;
  wire       tick;
  wire       tick_run;
  wire [2:0] clk_code;
  wire       rc_clock_sel;
  wire       sw_clear_start;
  wire       sw_set_start;
  wire       finish;
  wire       abort;
  assign clk_code       = timing_format_config[`ADCF_TIM_CLK_LSB +: 3];
  assign rc_clock_sel   = (clk_code[1:0] == 2'h3); // R8
  assign sw_set_start   = reg_write && (reg_addr == `ADCF_OFS_CONTROL) && reg_wdata[`ADCF_CTL_START];
  assign sw_clear_start = reg_write && (reg_addr == `ADCF_OFS_CONTROL) && !reg_wdata[`ADCF_CTL_START];
  assign finish         = (state == ST_CONV) && tick && (bit_index == 4'h0);
  assign abort          = (state == ST_ACQ || state == ST_CONV || state == ST_HOLD) && sw_clear_start;
  assign tick_run       = (state != ST_IDLE) && (state != ST_HOLD);
  adcf_tick_gen #(.RC_DIV(RC_DIV)) u_tick
  (
    .clock   (clock),
    .arst_n  (arst_n),
    .run     (tick_run),
    .clk_sel (clk_code),
    .tick    (tick)
  );
  // ----------------------------------------------------------------------
  // comparator input comes from the analog side, so synchronise it
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end
    else
    begin
      comp_meta <= comp_in;
      comp_sync <= comp_meta;
    end
  end
  // acquisition delay decode in conversion periods
  always @*
  begin
    case (timing_format_config[`ADCF_TIM_ACQ_LSB +: 3])
      3'h0:    acq_target = 5'd0;
      3'h1:    acq_target = 5'd2;
      3'h2:    acq_target = 5'd4;
      3'h3:    acq_target = 5'd6;
      3'h4:    acq_target = 5'd8;
      3'h5:    acq_target = 5'd12;
      3'h6:    acq_target = 5'd16;
      default: acq_target = 5'd20;
    endcase // R5
  end
  // ----------------------------------------------------------------------
  // partial result: unconverted bits copy the last bit decided
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 10; gi = gi + 1)
    begin : g_fill
      always @*
      begin
        if (gi <= bit_index)
          filled[gi] = last_bit; // R17
        else
          filled[gi] = sar[gi];
      end
    end
  endgenerate
  // last decided bit is the one just above the current trial bit
  always @*
  begin
    if (state != ST_CONV || bit_index == 4'h9)
      last_bit = sar[9];
    else
      last_bit = sar[bit_index + 4'h1];
  end
  // result value as it will be stored, full or partial
  always @*
  begin
    if (finish)
      next_result = {sar[9:1], comp_sync};
    else
      next_result = filled;
  end

  // ----------------------------------------------------------------------
  // configuration registers; a write only stores the implemented bits
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reference_config     <= `ADCF_RST_REF;    // R19
      timing_format_config <= `ADCF_RST_TIMING; // R19
      conv_enable          <= 1'b0;
      chan_sel             <= 4'h0;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        `ADCF_OFS_CONTROL:
        begin
          conv_enable <= reg_wdata[`ADCF_CTL_ENABLE];
          chan_sel    <= reg_wdata[`ADCF_CTL_CHAN_LSB +: 4];
        end
        `ADCF_OFS_REF_CFG:    reference_config     <= reg_wdata & `ADCF_REF_MASK; // R3
        `ADCF_OFS_TIMING_CFG: timing_format_config <= reg_wdata & `ADCF_TIM_MASK; // R4
        default:              reference_config     <= reference_config;
      endcase
    end
  end
  // reference select outputs follow the stored codes; reserved codes pass through
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pos_ref_sel <= `ADCF_POS_SUPPLY;
      neg_ref_sel <= `ADCF_NEG_GROUND;
    end
    else
    begin
      pos_ref_sel <= reference_config[`ADCF_REF_POS_LSB +: 2]; // R1
      neg_ref_sel <= reference_config[`ADCF_REF_NEG_LSB +: 2]; // R2
    end
  end

  // ----------------------------------------------------------------------
  // sequencer: hold, acquire, convert, discharge, gap
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state      <= ST_IDLE;
      start_busy <= 1'b0;
      acq_count  <= 5'h00;
      bit_index  <= 4'h9;
      sar        <= 10'h000;
      gap_count  <= 2'h0;
      hold_count <= 2'h0;
    end
    else if (abort)
    begin
      start_busy <= 1'b0;
      state      <= ST_DISCH; // R17
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (sw_set_start && (conv_enable || reg_wdata[`ADCF_CTL_ENABLE]))
          begin
            start_busy <= 1'b1;
            acq_count  <= 5'h00;
            hold_count <= 2'h0;
            state      <= rc_clock_sel ? ST_HOLD : ST_ACQ;
          end
        end
        ST_HOLD:
        begin
          // give software one instruction to reach sleep
          hold_count <= hold_count + 2'h1;
          if (hold_count == `ADCF_HOLD_LAST)
            state <= ST_ACQ; // R9
        end
        ST_ACQ:
        begin
          if (acq_count >= acq_target)
          begin
            bit_index <= 4'h9;
            sar       <= 10'h200;
            state     <= ST_CONV; // R6
          end
          else if (tick)
            acq_count <= acq_count + 5'h01;
        end
        ST_CONV:
        begin
          if (tick)
          begin
            sar[bit_index] <= comp_sync;
            if (bit_index == 4'h0)
            begin
              start_busy <= 1'b0; // R16
              state      <= ST_DISCH;
            end
            else
            begin
              bit_index          <= bit_index - 4'h1;
              sar[bit_index - 1] <= 1'b1;
            end
          end
        end
        ST_DISCH:
        begin
          gap_count <= 2'h0;
          state     <= ST_GAP; // R15
        end
        ST_GAP:
        begin
          if (tick)
          begin
            gap_count <= gap_count + 2'h1;
            if (gap_count == `ADCF_GAP_LAST)
              state <= ST_IDLE; // R18
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------------
  // result registers: hardware store on finish or on an abort during conversion, else software write
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      result_high_byte <= 8'h00;
      result_low_byte  <= 8'h00;
    end
    else if (finish || abort && state == ST_CONV)
    begin
      if (timing_format_config[`ADCF_TIM_JUSTIFY])
      begin
        result_high_byte <= {6'h00, next_result[9:8]}; // R12
        result_low_byte  <= next_result[7:0];          // R13
      end
      else
      begin
        result_high_byte <= next_result[9:2];          // R10
        result_low_byte  <= {next_result[1:0], 6'h00}; // R11
      end
    end
    else if (reg_write && reg_addr == `ADCF_OFS_RESULT_HIGH)
      result_high_byte <= reg_wdata;
    else if (reg_write && reg_addr == `ADCF_OFS_RESULT_LOW)
      result_low_byte <= reg_wdata;
  end
  // done flag: hardware set wins over a software clear in the same cycle
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      conv_done_flag <= 1'b0;
    else if (finish)
      conv_done_flag <= 1'b1; // R16
    else if (reg_write && reg_addr == `ADCF_OFS_STATUS && reg_wdata[0])
      conv_done_flag <= 1'b0;
  end
  // analog side controls
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sample_connect   <= 1'b0;
      sample_discharge <= 1'b0;
      dac_code         <= 10'h000;
    end
    else
    begin
      sample_connect   <= conv_enable && (state == ST_IDLE || state == ST_HOLD || state == ST_ACQ);
      sample_discharge <= (state == ST_DISCH); // R15
      dac_code         <= sar;
    end
  end

  // ----------------------------------------------------------------------
  // read port: data one cycle after the strobe; unmapped reads zero
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      case (reg_addr)
        `ADCF_OFS_CONTROL:     reg_rdata <= {2'h0, chan_sel, start_busy, conv_enable};
        `ADCF_OFS_REF_CFG:     reg_rdata <= reference_config;
        `ADCF_OFS_TIMING_CFG:  reg_rdata <= timing_format_config;
        `ADCF_OFS_RESULT_HIGH: reg_rdata <= result_high_byte;
        `ADCF_OFS_RESULT_LOW:  reg_rdata <= result_low_byte;
        `ADCF_OFS_STATUS:      reg_rdata <= {7'h00, conv_done_flag};
        default:               reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// >>> sim/adcf_props.sv
// port checker of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcf_props
#(
  parameter RC_DIV = 41
)
(
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       comp_in,
  input wire logic [1:0] pos_ref_sel,
  input wire logic [1:0] neg_ref_sel,
  input wire logic [3:0] chan_sel,
  input wire logic       sample_connect,
  input wire logic       sample_discharge,
  input wire logic [9:0] dac_code,
  input wire logic       conv_done_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ----------------
  // helper logic
  // ----------------
  // cycles since the last discharge, saturating so it never wraps
  logic [7:0] disc_age;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      disc_age <= 8'hff;
    else if (sample_discharge)
      disc_age <= 8'h00;
    else if (disc_age != 8'hff)
      disc_age <= disc_age + 8'h01;
  end
  sequence s_ref_wr;
    reg_write && reg_addr == 3'h1;
  endsequence
  sequence s_clr_flag;
    reg_write && reg_addr == 3'h5 && reg_wdata[0];
  endsequence
  // ----------------
  // properties
  // ----------------
  property p_rdata_idle;
    !reg_read |=> reg_rdata == 8'h00;
  endproperty
  property p_ref_upper;
    reg_read && reg_addr == 3'h1 |=> reg_rdata[7:4] == 4'h0;
  endproperty
  property p_tim_bit6;
    reg_read && reg_addr == 3'h2 |=> !reg_rdata[6];
  endproperty
  property p_pos_follow;
    logic [1:0] v;
    (s_ref_wr, v = reg_wdata[3:2]) |=> ##1 pos_ref_sel == v;
  endproperty
  property p_neg_follow;
    logic [1:0] v;
    (s_ref_wr, v = reg_wdata[1:0]) |=> ##1 neg_ref_sel == v;
  endproperty
  // set wins over a clear, so only a clear may drop the flag
  property p_flag_hold;
    conv_done_flag && !reg_write |=> conv_done_flag;
  endproperty
  property p_disc_pulse;
    sample_discharge |=> !sample_discharge;
  endproperty
  property p_done_disc;
    $rose(conv_done_flag) |-> ##[0:3] (disc_age < 8'd6);
  endproperty
  property p_flag_clr;
    s_clr_flag ##1 !$rose(conv_done_flag) |-> !conv_done_flag;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  a_ref_upper: assert property (p_ref_upper) else $error("reference upper nibble not zero");
  a_tim_bit6: assert property (p_tim_bit6) else $error("timing bit 6 not zero");
  a_pos_follow: assert property (p_pos_follow) else $error("positive reference select wrong");
  a_neg_follow: assert property (p_neg_follow) else $error("negative reference select wrong");
  a_flag_hold: assert property (p_flag_hold) else $error("done flag dropped");
  a_disc_pulse: assert property (p_disc_pulse) else $error("discharge longer than a cycle");
  a_done_disc: assert property (p_done_disc) else $error("no discharge at completion");
  a_flag_clr: assert property (p_flag_clr) else $error("done flag not cleared");
endmodule
bind adcf_core adcf_props #(.RC_DIV(RC_DIV)) u_props (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .comp_in(comp_in),
  .pos_ref_sel(pos_ref_sel), .neg_ref_sel(neg_ref_sel), .chan_sel(chan_sel), .sample_connect(sample_connect),
  .sample_discharge(sample_discharge), .dac_code(dac_code), .conv_done_flag(conv_done_flag));
`default_nettype wire

// >>> sim/adc_config_and_result_format_bench.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adcf_map.vh"
`define ADCF_CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("Error %0t: got %h want %h", $time, g, e); \
    end \
  end
module adc_config_and_result_format_bench;
  localparam int RCD = 6;
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic       comp_in = 1'b0;
  logic [1:0] pos_ref_sel;
  logic [1:0] neg_ref_sel;
  logic [3:0] chan_sel;
  logic       sample_connect;
  logic       sample_discharge;
  logic [9:0] dac_code;
  logic       conv_done_flag;
  logic [9:0] target = 10'h000;
  int         err_total = 0;
  int         checks_done = 0;
  int         cyc = 0;
  adcf_core #(.RC_DIV(RCD)) uut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .comp_in(comp_in),
    .pos_ref_sel(pos_ref_sel), .neg_ref_sel(neg_ref_sel), .chan_sel(chan_sel), .sample_connect(sample_connect),
    .sample_discharge(sample_discharge), .dac_code(dac_code), .conv_done_flag(conv_done_flag));
  // ----------------
  // clock, comparator, watchdog
  // ----------------
  // 25 MHz system clock
  always #20 clock = ~clock;
  // ideal comparator: keep the trial bit while the trial code is not above the input
  always @(posedge clock)
    comp_in <= (dac_code <= target);
  // cut a hang short well past the expected run length
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      summarize();
    end
  end
  // ----------------
  // bus tasks
  // ----------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    `ADCF_CHK(reg_rdata, e)
  endtask
  // one conversion on channel 4, after the gap of a slow clock; n counts cycles to the flag
  task automatic conv(input logic [7:0] tim, input logic [9:0] t, output int n);
    repeat (140) @(posedge clock);
    wr(`ADCF_OFS_STATUS, 8'h01);
    wr(`ADCF_OFS_TIMING_CFG, tim);
    target <= t;
    wr(`ADCF_OFS_CONTROL, 8'h13);
    n = 0;
    while (conv_done_flag !== 1'b1 && n < 3000)
    begin
      @(negedge clock);
      n++;
    end
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_regs;
    rdc(`ADCF_OFS_REF_CFG, 8'h00);
    rdc(`ADCF_OFS_TIMING_CFG, 8'h00);
    rdc(3'h6, 8'h00);
    wr(3'h7, 8'hff);
    for (int i = 0; i < 16; i++)
    begin
      wr(`ADCF_OFS_REF_CFG, {4'hf, i[3:0]});
      rdc(`ADCF_OFS_REF_CFG, {4'h0, i[3:0]});
      if (i[3:2] != 2'h3) `ADCF_CHK(pos_ref_sel, i[3:2])
      if (i[1:0] < 2'h2) `ADCF_CHK(neg_ref_sel, i[1:0])
    end
    wr(`ADCF_OFS_TIMING_CFG, 8'hff);
    rdc(`ADCF_OFS_TIMING_CFG, 8'hbf);
  endtask
  task automatic t_fmt;
    int n;
    conv(8'h01, 10'h2d9, n);
    `ADCF_CHK(conv_done_flag, 1'b1)
    `ADCF_CHK(chan_sel, 4'h4)
    rdc(`ADCF_OFS_CONTROL, 8'h11);
    rdc(`ADCF_OFS_RESULT_HIGH, 8'hb6);
    rdc(`ADCF_OFS_RESULT_LOW, 8'h40);
    `ADCF_CHK(dac_code, 10'h2d9)
    wr(`ADCF_OFS_STATUS, 8'h01);
    @(negedge clock);
    `ADCF_CHK(conv_done_flag, 1'b0)
    conv(8'h81, 10'h2d9, n);
    rdc(`ADCF_OFS_RESULT_HIGH, 8'h02);
    rdc(`ADCF_OFS_RESULT_LOW, 8'hd9);
  endtask
  // extra time per acquisition code must match the period table at divide-by-8
  task automatic t_acq;
    int n0;
    int n;
    int per[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    conv(8'h01, 10'h155, n0);
    for (int k = 1; k < 8; k++)
    begin
      conv({2'b00, k[2:0], 3'b001}, 10'h155, n);
      `ADCF_CHK(n - n0 >= per[k] * 8 - 8 && n - n0 <= per[k] * 8 + 8, 1'b1)
    end
    rdc(`ADCF_OFS_RESULT_HIGH, 8'h55);
  endtask
  // conversion length follows the divider; rc codes add the one-instruction hold
  task automatic t_clk;
    int n;
    int lo;
    int nrc;
    int dv[8] = '{2, 8, 32, RCD, 4, 16, 64, RCD};
    for (int k = 0; k < 8; k++)
    begin
      conv({5'h00, k[2:0]}, 10'h155, n);
      lo = dv[k] * 10 + ((k[1:0] == 2'h3) ? 4 : 0);
      `ADCF_CHK(n >= lo && n <= dv[k] * 12 + 16, 1'b1)
      if (k == 3)
        nrc = n;
      if (k == 7) `ADCF_CHK(n - nrc <= RCD && nrc - n <= RCD, 1'b1)
    end
  endtask
  // abort after five decided bits of 0x3c0: the fifth is zero, so the open trial bit and the rest fill with zeros
  task automatic t_abort;
    int n;
    repeat (140) @(posedge clock);
    wr(`ADCF_OFS_STATUS, 8'h01);
    wr(`ADCF_OFS_TIMING_CFG, 8'h01);
    target <= 10'h3c0;
    wr(`ADCF_OFS_CONTROL, 8'h13);
    repeat (44) @(posedge clock);
    wr(`ADCF_OFS_CONTROL, 8'h11);
    n = 0;
    while (sample_discharge !== 1'b1 && n < 40)
    begin
      @(negedge clock);
      n++;
    end
    `ADCF_CHK(sample_discharge, 1'b1)
    `ADCF_CHK(sample_connect, 1'b0)
    rdc(`ADCF_OFS_RESULT_HIGH, 8'hf0);
    rdc(`ADCF_OFS_RESULT_LOW, 8'h00);
    `ADCF_CHK(conv_done_flag, 1'b0)
    // two divide-by-8 periods of gap are long over, so the channel is back on
    repeat (20) @(negedge clock);
    `ADCF_CHK(sample_connect, 1'b1)
  endtask
  task automatic summarize;
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_fmt();
    t_acq();
    t_clk();
    t_abort();
    summarize();
  end
endmodule
`default_nettype wire
